// >>> rtl/protected_regs_ident_osc_ctrl.sv
// Register locking, identification, 32 kHz oscillator enable and clock routing
//
// Notes on behaviour
// (RULE1) Protected words start locked; writes while locked change nothing.
// (RULE2) Protected writes allowed only while lock key holds 0x0013.
// (RULE3) Lock key is 16 bits and resets to zero.
// (RULE4) Software should relock straight after its protected writes.
// (RULE5) Writing any other key value relocks the protected words.
// (RULE6) Offset 0x00 reads a fixed identification code.
// (RULE7) Offset 0x01 reads functional revision, config pins, customer revision.
// (RULE8) Bit 10 at 0x0C enables the crystal oscillator; resets to one.
// (RULE9) Oscillator enable holds its state in off and backup power states.
// (RULE10) Enable also at 0xDA; both addresses share one storage bit.
// (RULE11) Start-up and system ticks come from the internal RC rate.
// (RULE12) Converter ticks run at 2 MHz and 1 MHz from RC rate.
// (RULE13) Loop reference selects master clock, frame clocks in slave, 32 kHz.
// (RULE14) Codec system clock is master clock or loop output.
// (RULE15) Bit 11 at 0x28 picks loop output; resets to master clock.
// (RULE16) External 32 kHz accepted on crystal pin or general-purpose input.
// (RULE17) 32 kHz signal routable to general-purpose pins 2, 3, 5, 12.
`timescale 1ns/1ps
`default_nettype none
module protected_regs_ident_osc_ctrl (
	input  wire logic                          clk_in,
	input  wire logic                          rstn_in,
	input  wire protected_regs_pkg::reg_req_s  req_in,
	output protected_regs_pkg::reg_rsp_s       rsp_out,
	input  wire logic [1:0]                    config_pin_state_in,
	input  wire logic                          slave_mode_in,
	input  wire logic                          mclk_in,
	input  wire logic                          freq_locked_loop_in,
	input  wire logic                          adc_frame_clock_in,
	input  wire logic                          dac_frame_clock_in,
	input  wire logic                          xtal_osc_core_in,
	input  wire logic                          crystal_pin_in,
	input  wire logic                          gpio_32k_in,
	output logic                               xtal_osc_enable_out,
	output logic                               unlocked_out,
	output logic                               codec_system_clock_out,
	output logic                               freq_locked_loop_ref_out,
	output logic                               clk_32k_out,
	output logic [3:0]                         gpio_32k_out,
	output logic                               rc_system_tick_out,
	output logic                               conv_fast_tick_out,
	output logic                               conv_slow_tick_out
);

	// ----------------------------------------------------------------
	// Address decoding
	// ----------------------------------------------------------------
	function automatic logic is_protected(input logic [7:0] addr);
		unique case (addr)
			protected_regs_pkg::OFF_PROT_SYS_A,
			protected_regs_pkg::OFF_PROT_SYS_B,
			protected_regs_pkg::OFF_PROT_SYS_C,
			protected_regs_pkg::OFF_POWER_MGMT,
			protected_regs_pkg::OFF_PROT_CHG_A,
			protected_regs_pkg::OFF_PROT_CHG_B,
			protected_regs_pkg::OFF_PROT_CHG_C: is_protected = 1'b1;
			default:                            is_protected = 1'b0;
		endcase
	endfunction

	function automatic logic [2:0] prot_index(input logic [7:0] addr);
		unique case (addr)
			protected_regs_pkg::OFF_PROT_SYS_A: prot_index = 3'h0;
			protected_regs_pkg::OFF_PROT_SYS_B: prot_index = 3'h1;
			protected_regs_pkg::OFF_PROT_SYS_C: prot_index = 3'h2;
			protected_regs_pkg::OFF_POWER_MGMT: prot_index = 3'h3;
			protected_regs_pkg::OFF_PROT_CHG_A: prot_index = 3'h4;
			protected_regs_pkg::OFF_PROT_CHG_B: prot_index = 3'h5;
			protected_regs_pkg::OFF_PROT_CHG_C: prot_index = 3'h6;
			default:                            prot_index = 3'h7;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [15:0] lock_key;
	logic        unlocked;
	logic        xtal_osc_enable;
	logic [15:0] tick_control;
	logic [15:0] clock_control;
	logic [15:0] clock_route;
	logic [1:0]  config_pin_state;
	logic        config_captured;
	logic        prot_we;
	logic [15:0] prot_rdata;
	logic        rd_pend;
	logic [7:0]  rd_addr;
	logic [15:0] next_rdata;
	logic        next_clk_32k;
	logic        next_fll_ref;
	logic        rc_tick;
	logic        slow_phase;
	logic        wr_pmgmt;
	logic        wr_tick;

	assign unlocked = (lock_key == protected_regs_pkg::LOCK_KEY_UNLOCK);  // RULE2
	assign prot_we  = req_in.wr && is_protected(req_in.addr) && unlocked;  // RULE1
	assign wr_pmgmt = prot_we && req_in.addr == protected_regs_pkg::OFF_POWER_MGMT;
	assign wr_tick  = req_in.wr && req_in.addr == protected_regs_pkg::OFF_TICK_CONTROL;

	// ----------------------------------------------------------------
	// Protected storage
	// ----------------------------------------------------------------
	prot_store u_prot_store (
		.clk_in    (clk_in),
		.rstn_in   (rstn_in),
		.we_in     (prot_we),
		.waddr_in  (prot_index(req_in.addr)),
		.wdata_in  (req_in.wdata),
		.raddr_in  (prot_index(req_in.addr)),
		.rdata_out (prot_rdata)
	);

	// ----------------------------------------------------------------
	// Lock key
	// ----------------------------------------------------------------
	// Any value but the key relocks, so a stray write fails safe
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			lock_key <= protected_regs_pkg::LOCK_KEY_RESET;  // RULE3
		end else if (req_in.wr && req_in.addr == protected_regs_pkg::OFF_LOCK_KEY) begin
			lock_key <= req_in.wdata;  // RULE5
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			unlocked_out <= 1'b0;
		end else begin
			unlocked_out <= unlocked;
		end
	end

	// ----------------------------------------------------------------
	// Oscillator enable, one bit seen at two addresses
	// ----------------------------------------------------------------
	// No power-state input clears it: it lives on the backup supply
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			xtal_osc_enable <= protected_regs_pkg::XTAL_EN_RESET;  // RULE8
		end else if (wr_pmgmt) begin
			xtal_osc_enable <= req_in.wdata[protected_regs_pkg::XTAL_EN_BIT_PMGMT];  // RULE8
		end else if (wr_tick) begin
			xtal_osc_enable <= req_in.wdata[protected_regs_pkg::XTAL_EN_BIT_TICK];  // RULE10
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			xtal_osc_enable_out <= protected_regs_pkg::XTAL_EN_RESET;
		end else begin
			xtal_osc_enable_out <= xtal_osc_enable;  // RULE9
		end
	end

	// ----------------------------------------------------------------
	// Unprotected control words
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tick_control <= protected_regs_pkg::WORD_RESET;
		end else if (wr_tick) begin
			tick_control <= req_in.wdata;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			clock_control <= protected_regs_pkg::WORD_RESET;  // RULE15
		end else if (req_in.wr && req_in.addr == protected_regs_pkg::OFF_CLOCK_CONTROL) begin
			clock_control <= req_in.wdata;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			clock_route <= protected_regs_pkg::WORD_RESET;
		end else if (req_in.wr && req_in.addr == protected_regs_pkg::OFF_CLOCK_ROUTE) begin
			clock_route <= req_in.wdata;
		end
	end

	// Pins caught once, on the first edge after reset release
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			config_pin_state <= 2'h0;
			config_captured  <= 1'b0;
		end else if (!config_captured) begin
			config_pin_state <= config_pin_state_in;  // RULE7
			config_captured  <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Read path, answer two cycles after the request
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rd_pend <= 1'b0;
			rd_addr <= 8'h00;
		end else begin
			rd_pend <= req_in.rd;
			rd_addr <= req_in.addr;
		end
	end

	always_comb begin
		next_rdata = protected_regs_pkg::WORD_RESET;
		if (is_protected(rd_addr)) begin
			next_rdata = prot_rdata;
			if (rd_addr == protected_regs_pkg::OFF_POWER_MGMT) begin
				next_rdata[protected_regs_pkg::XTAL_EN_BIT_PMGMT] = xtal_osc_enable;  // RULE10
			end
		end else begin
			unique case (rd_addr)
				protected_regs_pkg::OFF_IDENT: begin
					next_rdata = protected_regs_pkg::IDENT_CODE;  // RULE6
				end
				protected_regs_pkg::OFF_DEVICE_INFO: begin
					next_rdata[protected_regs_pkg::FUNC_REV_LSB +: 4] =
						protected_regs_pkg::FUNC_REVISION;  // RULE7
					next_rdata[protected_regs_pkg::CONF_PIN_LSB +: 2] = config_pin_state;
					next_rdata[7:0] = protected_regs_pkg::CUSTOMER_REVISION;
				end
				protected_regs_pkg::OFF_MASK_REVISION: begin
					next_rdata[7:0] = protected_regs_pkg::ROM_MASK_REVISION;
				end
				protected_regs_pkg::OFF_TICK_CONTROL: begin
					next_rdata = tick_control;
					next_rdata[protected_regs_pkg::XTAL_EN_BIT_TICK] = xtal_osc_enable;  // RULE10
				end
				protected_regs_pkg::OFF_LOCK_KEY: begin
					next_rdata = lock_key;
				end
				protected_regs_pkg::OFF_CLOCK_CONTROL: begin
					next_rdata = clock_control;
				end
				protected_regs_pkg::OFF_CLOCK_ROUTE: begin
					next_rdata = clock_route;
				end
				default: begin
					next_rdata = protected_regs_pkg::WORD_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rsp_out <= '0;
		end else begin
			rsp_out.valid <= rd_pend;
			rsp_out.data  <= rd_pend ? next_rdata : protected_regs_pkg::WORD_RESET;
		end
	end

	// ----------------------------------------------------------------
	// Clock routing
	// ----------------------------------------------------------------
	// Clocks are sampled at clk_in, so routed copies carry one cycle of jitter
	always_comb begin
		unique case (clock_route[protected_regs_pkg::SRC32K_LSB +: 2])
			protected_regs_pkg::SRC32K_XTAL: next_clk_32k = xtal_osc_core_in & xtal_osc_enable;
			protected_regs_pkg::SRC32K_PIN:  next_clk_32k = crystal_pin_in;  // RULE16
			protected_regs_pkg::SRC32K_GPIO: next_clk_32k = gpio_32k_in;  // RULE16
			default:                         next_clk_32k = 1'b0;
		endcase
	end

	// Frame clocks are inputs only in slave modes
	always_comb begin
		unique case (clock_route[protected_regs_pkg::FLL_REF_LSB +: 2])
			protected_regs_pkg::FLL_REF_MCLK:      next_fll_ref = mclk_in;  // RULE13
			protected_regs_pkg::FLL_REF_ADC_FRAME: next_fll_ref = adc_frame_clock_in & slave_mode_in;
			protected_regs_pkg::FLL_REF_DAC_FRAME: next_fll_ref = dac_frame_clock_in & slave_mode_in;
			protected_regs_pkg::FLL_REF_32K:       next_fll_ref = next_clk_32k;
		endcase
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			clk_32k_out  <= 1'b0;
			gpio_32k_out <= 4'h0;
		end else begin
			clk_32k_out  <= next_clk_32k;
			gpio_32k_out <= {4{next_clk_32k}} & clock_route[protected_regs_pkg::GPIO32K_LSB +: 4];  // RULE17
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			freq_locked_loop_ref_out <= 1'b0;
			codec_system_clock_out   <= 1'b0;
		end else begin
			freq_locked_loop_ref_out <= next_fll_ref;  // RULE13
			codec_system_clock_out   <= clock_control[protected_regs_pkg::CODEC_SYSTEM_CLOCK_SRC_BIT] ?
				freq_locked_loop_in : mclk_in;  // RULE14 RULE15
		end
	end

	// ----------------------------------------------------------------
	// RC-derived ticks
	// ----------------------------------------------------------------
	rate_divider #(
		.DIV (protected_regs_pkg::RC_OSC_CYCLES)
	) u_rc_divider (
		.clk_in   (clk_in),
		.rstn_in  (rstn_in),
		.tick_out (rc_tick)
	);

	// Slow converter tick on every other RC tick
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			slow_phase <= 1'b0;
		end else if (rc_tick) begin
			slow_phase <= ~slow_phase;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rc_system_tick_out <= 1'b0;
			conv_fast_tick_out <= 1'b0;
			conv_slow_tick_out <= 1'b0;
		end else begin
			rc_system_tick_out <= rc_tick;  // RULE11
			conv_fast_tick_out <= rc_tick;  // RULE12
			conv_slow_tick_out <= rc_tick & slow_phase;  // RULE12
		end
	end

endmodule
`default_nettype wire

// >>> rtl/protected_regs_pkg.sv
// Constants, encodings and carrier structs for the protected register block
package protected_regs_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_IDENT          = 8'h00;
	localparam logic [7:0] OFF_DEVICE_INFO    = 8'h01;
	localparam logic [7:0] OFF_MASK_REVISION  = 8'h02;
	localparam logic [7:0] OFF_PROT_SYS_A     = 8'h03;
	localparam logic [7:0] OFF_PROT_SYS_B     = 8'h04;
	localparam logic [7:0] OFF_PROT_SYS_C     = 8'h06;
	localparam logic [7:0] OFF_POWER_MGMT     = 8'h0C;
	localparam logic [7:0] OFF_CLOCK_CONTROL  = 8'h28;
	localparam logic [7:0] OFF_PROT_CHG_A     = 8'hA8;
	localparam logic [7:0] OFF_PROT_CHG_B     = 8'hA9;
	localparam logic [7:0] OFF_PROT_CHG_C     = 8'hAA;
	localparam logic [7:0] OFF_TICK_CONTROL   = 8'hDA;
	localparam logic [7:0] OFF_LOCK_KEY       = 8'hDB;
	localparam logic [7:0] OFF_CLOCK_ROUTE    = 8'hE0;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] LOCK_KEY_UNLOCK   = 16'h0013;
	localparam logic [15:0] LOCK_KEY_RESET    = 16'h0000;
	localparam logic [15:0] WORD_RESET        = 16'h0000;
	localparam logic [3:0]  XTAL_EN_BIT_PMGMT = 4'hA;
	localparam logic [3:0]  XTAL_EN_BIT_TICK  = 4'hC;
	localparam logic        XTAL_EN_RESET     = 1'b1;
	localparam logic [3:0]  CODEC_SYSTEM_CLOCK_SRC_BIT    = 4'hB;
	localparam logic [3:0]  FLL_REF_LSB       = 4'h0;
	localparam logic [3:0]  SRC32K_LSB        = 4'h2;
	localparam logic [3:0]  GPIO32K_LSB       = 4'h4;
	localparam logic [2:0]  PROT_WORDS        = 3'h7;
	localparam logic [3:0]  FUNC_REV_LSB      = 4'hC;
	localparam logic [3:0]  CONF_PIN_LSB      = 4'hA;

	// Identification values, arbitrary
	localparam logic [15:0] IDENT_CODE        = 16'hA5C3;
	localparam logic [3:0]  FUNC_REVISION     = 4'h1;
	localparam logic [7:0]  CUSTOMER_REVISION = 8'h01;
	localparam logic [7:0]  ROM_MASK_REVISION = 8'h01;

	// ----------------------------------------------------------------
	// Clock rates in kHz and derived cycle counts
	// ----------------------------------------------------------------
	localparam int CLK_KHZ        = 100000;
	localparam int RC_OSC_KHZ     = 2000;
	localparam int CONV_FAST_KHZ  = 2000;
	localparam int CONV_SLOW_KHZ  = 1000;
	localparam int RC_OSC_CYCLES  = CLK_KHZ / RC_OSC_KHZ;
	localparam int CONV_SLOW_DIV  = CONV_FAST_KHZ / CONV_SLOW_KHZ;

	// ----------------------------------------------------------------
	// Encodings and carriers
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		FLL_REF_MCLK      = 2'b00,
		FLL_REF_ADC_FRAME = 2'b01,
		FLL_REF_DAC_FRAME = 2'b10,
		FLL_REF_32K       = 2'b11
	} fll_ref_e;

	typedef enum logic [1:0] {
		SRC32K_XTAL = 2'b00,
		SRC32K_PIN  = 2'b01,
		SRC32K_GPIO = 2'b10
	} src32k_e;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} reg_rsp_s;

endpackage

// >>> rtl/rate_divider.sv
// Divider giving a one-cycle enable pulse every DIV clocks
`timescale 1ns/1ps
`default_nettype none
module rate_divider #(
	parameter int DIV = 50
) (
	input  wire logic clk_in,
	input  wire logic rstn_in,
	output logic      tick_out
);

	logic [7:0] count;

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			count    <= 8'h00;
			tick_out <= 1'b0;
		end else if (count == 8'(DIV - 1)) begin
			count    <= 8'h00;
			tick_out <= 1'b1;
		end else begin
			count    <= count + 8'h01;
			tick_out <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// >>> rtl/prot_store.sv
// Storage for the write-protected register words, registered read
`timescale 1ns/1ps
`default_nettype none
module prot_store (
	input  wire logic        clk_in,
	input  wire logic        rstn_in,
	input  wire logic        we_in,
	input  wire logic [2:0]  waddr_in,
	input  wire logic [15:0] wdata_in,
	input  wire logic [2:0]  raddr_in,
	output logic      [15:0] rdata_out
);

	logic [15:0] mem [protected_regs_pkg::PROT_WORDS];

	// Small enough to clear on reset, so contents are defined
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			for (int i = 0; i < int'(protected_regs_pkg::PROT_WORDS); i++) begin
				mem[i] <= protected_regs_pkg::WORD_RESET;
			end
		end else if (we_in && waddr_in < protected_regs_pkg::PROT_WORDS) begin
			mem[waddr_in] <= wdata_in;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rdata_out <= protected_regs_pkg::WORD_RESET;
		end else if (raddr_in < protected_regs_pkg::PROT_WORDS) begin
			rdata_out <= mem[raddr_in];
		end else begin
			rdata_out <= protected_regs_pkg::WORD_RESET;
		end
	end

endmodule
`default_nettype wire

// >>> sim/protected_regs_chk.sv
// Concurrent checks on the protected register block ports
`timescale 1ns/1ps
`default_nettype none
module protected_regs_chk (
	input wire logic                         clk_in,
	input wire logic                         rstn_in,
	input wire protected_regs_pkg::reg_req_s req_in,
	input wire protected_regs_pkg::reg_rsp_s rsp_out,
	input wire logic                         xtal_osc_enable_out,
	input wire logic                         unlocked_out,
	input wire logic                         rc_system_tick_out,
	input wire logic                         conv_fast_tick_out,
	input wire logic                         conv_slow_tick_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	// ------------------------------------------------------------
	// Decoded writes
	// ------------------------------------------------------------
	logic wr_key;
	logic wr_tick;
	logic wr_pm;
	assign wr_key  = req_in.wr && req_in.addr == protected_regs_pkg::OFF_LOCK_KEY;
	assign wr_tick = req_in.wr && req_in.addr == protected_regs_pkg::OFF_TICK_CONTROL;
	assign wr_pm   = req_in.wr && req_in.addr == protected_regs_pkg::OFF_POWER_MGMT;
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	property p_rsp_time; req_in.rd |-> ##2 rsp_out.valid; endproperty
	a_rsp_time: assert property (p_rsp_time) else $error("no answer");
	property p_rsp_cause; rsp_out.valid |-> $past(req_in.rd, 2); endproperty
	a_rsp_cause: assert property (p_rsp_cause) else $error("stray answer");
	property p_rsp_idle; !rsp_out.valid |-> rsp_out.data == 16'h0000; endproperty
	a_rsp_idle: assert property (p_rsp_idle) else $error("data while idle");
	property p_ident; req_in.rd && req_in.addr == protected_regs_pkg::OFF_IDENT
		|-> ##2 rsp_out.data == protected_regs_pkg::IDENT_CODE; endproperty
	a_ident: assert property (p_ident) else $error("bad ident word");
	property p_info; req_in.rd && req_in.addr == protected_regs_pkg::OFF_DEVICE_INFO
		|-> ##2 rsp_out.data[15:12] == protected_regs_pkg::FUNC_REVISION
		&& rsp_out.data[7:0] == protected_regs_pkg::CUSTOMER_REVISION; endproperty
	a_info: assert property (p_info) else $error("bad device info");
	property p_unlock; wr_key && req_in.wdata == protected_regs_pkg::LOCK_KEY_UNLOCK
		|-> ##2 unlocked_out; endproperty
	a_unlock: assert property (p_unlock) else $error("not unlocked");
	property p_relock; wr_key && req_in.wdata != protected_regs_pkg::LOCK_KEY_UNLOCK
		|-> ##2 !unlocked_out; endproperty
	a_relock: assert property (p_relock) else $error("still unlocked");
	property p_alias; wr_tick |-> ##2 xtal_osc_enable_out == $past(req_in.wdata[12], 2);
	endproperty
	a_alias: assert property (p_alias) else $error("alias ignored");
	// Only software may move the enable, no power state does
	property p_hold; $changed(xtal_osc_enable_out) |-> $past(wr_tick, 2) || $past(wr_pm, 2);
	endproperty
	a_hold: assert property (p_hold) else $error("enable moved");
	property p_rc; rc_system_tick_out |=> !rc_system_tick_out ##49 rc_system_tick_out;
	endproperty
	a_rc: assert property (p_rc) else $error("rc tick");
	property p_fast; conv_fast_tick_out |=> !conv_fast_tick_out ##49 conv_fast_tick_out;
	endproperty
	a_fast: assert property (p_fast) else $error("fast tick");
	property p_slow; conv_slow_tick_out |=> !conv_slow_tick_out ##99 conv_slow_tick_out;
	endproperty
	a_slow: assert property (p_slow) else $error("slow tick");
endmodule
bind protected_regs_ident_osc_ctrl protected_regs_chk i_protected_regs_chk (
	.clk_in(clk_in), .rstn_in(rstn_in), .req_in(req_in), .rsp_out(rsp_out),
	.xtal_osc_enable_out(xtal_osc_enable_out), .unlocked_out(unlocked_out),
	.rc_system_tick_out(rc_system_tick_out), .conv_fast_tick_out(conv_fast_tick_out),
	.conv_slow_tick_out(conv_slow_tick_out)
);
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for the protected register block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic                         clk_in;
	logic                         rstn_in;
	protected_regs_pkg::reg_req_s req;
	protected_regs_pkg::reg_rsp_s rsp;
	logic [1:0]                   cfg;
	logic [7:0]                   ins = 8'h00;
	logic [7:0]                   hold;
	logic                         xen, unl, codec_system_clock, fref, c32, t_rc, t_fast, t_slow;
	logic [3:0]                   g32;
	int                           n_errors, comparisons;
	logic [15:0]                  exp_q[$];
	logic [31:0]                  seed;
	logic [15:0]                  stored[7];
	logic [7:0]                   prot[7] = '{8'h03, 8'h04, 8'h06, 8'h0C, 8'hA8, 8'hA9, 8'hAA};
	logic [15:0]                  pd[9] = '{16'h0000, 16'h0800, 16'h0000, 16'h0001, 16'h0002,
		16'h00F3, 16'h0057, 16'h00AB, 16'h00FF};
	int                           src[9] = '{0, 1, 0, 2, 3, 4, 5, 6, 8};
	// ------------------------------------------------------------
	// Design
	// ------------------------------------------------------------
	protected_regs_ident_osc_ctrl i_protected_regs_ident_osc_ctrl (
		.clk_in(clk_in), .rstn_in(rstn_in), .req_in(req), .rsp_out(rsp),
		.config_pin_state_in(cfg), .slave_mode_in(ins[7]), .mclk_in(ins[0]),
		.freq_locked_loop_in(ins[1]), .adc_frame_clock_in(ins[2]),
		.dac_frame_clock_in(ins[3]), .xtal_osc_core_in(ins[4]), .crystal_pin_in(ins[5]),
		.gpio_32k_in(ins[6]), .xtal_osc_enable_out(xen), .unlocked_out(unl),
		.codec_system_clock_out(codec_system_clock), .freq_locked_loop_ref_out(fref), .clk_32k_out(c32),
		.gpio_32k_out(g32), .rc_system_tick_out(t_rc), .conv_fast_tick_out(t_fast),
		.conv_slow_tick_out(t_slow)
	);
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	function automatic logic [15:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[15:0];
	endfunction
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_in);
		req <= {1'b1, 1'b0, a, d};
		@(posedge clk_in);
		req <= '0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		@(posedge clk_in);
		req <= {1'b0, 1'b1, a, 16'h0000};
		@(posedge clk_in);
		req <= '0;
	endtask
	// Inputs held a cycle back; frame clocks count in slave mode only
	task automatic path(input int k);
		logic [8:0] hx;
		logic       g;
		wr_reg(k < 2 ? protected_regs_pkg::OFF_CLOCK_CONTROL : protected_regs_pkg::OFF_CLOCK_ROUTE,
			pd[k]);
		repeat (3) @(negedge clk_in);
		repeat (20) begin
			hold = ins;
			@(negedge clk_in);
			hx = {1'b0, hold[7:4], hold[3:2] & {2{hold[7]}}, hold[1:0]};
			g = k < 2 ? codec_system_clock : (k < 5 ? fref : c32);
			chk("clock path", {15'h0000, hx[src[k]]}, {15'h0000, g});
			if (k > 4)
				chk("gpio ref", {11'h0, hx[src[k]], {4{c32}} & pd[k][7:4]}, {11'h0, fref, g32});
		end
	endtask
	task automatic count(input string nm, input int e);
		int n;
		n = 0;
		repeat (500) begin
			@(negedge clk_in);
			n += nm == "rc" ? t_rc : (nm == "fast" ? t_fast : t_slow);
		end
		chk(nm, e[15:0], n[15:0]);
	endtask
	task automatic test_done;
		if (exp_q.size() != 0)
			n_errors++;
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ------------------------------------------------------------
	// Stimulus and monitor
	// ------------------------------------------------------------
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) ins <= 8'(rnd() >> 3);
	always @(negedge clk_in) begin
		if (rsp.valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				n_errors++;
				$display("unexpected answer expected none seen %h", rsp.data);
			end else
				chk("read data", exp_q.pop_front(), rsp.data);
		end
	end
	initial begin
		repeat (20000) @(posedge clk_in);
		n_errors++;
		test_done();
	end
	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		logic [15:0] v;
		rstn_in = 1'b0;
		req = '0;
		seed = 32'h6A6E;
		n_errors = 0;
		comparisons = 0;
		cfg = 2'(rnd() >> 7);
		for (int i = 0; i < 7; i++)
			stored[i] = prot[i] == protected_regs_pkg::OFF_POWER_MGMT ? 16'h0400 : 16'h0000;
		repeat (5) @(posedge clk_in);
		rstn_in <= 1'b1;
		rd_reg(protected_regs_pkg::OFF_LOCK_KEY, 16'h0000);
		rd_reg(protected_regs_pkg::OFF_POWER_MGMT, 16'h0400);
		rd_reg(protected_regs_pkg::OFF_TICK_CONTROL, 16'h1000);
		rd_reg(protected_regs_pkg::OFF_CLOCK_CONTROL, 16'h0000);
		chk("osc enable", 16'h0001, {15'h0000, xen});
		wr_reg(protected_regs_pkg::OFF_IDENT, 16'hFFFF);
		rd_reg(protected_regs_pkg::OFF_IDENT, protected_regs_pkg::IDENT_CODE);
		rd_reg(protected_regs_pkg::OFF_DEVICE_INFO, {protected_regs_pkg::FUNC_REVISION, cfg,
			2'b00, protected_regs_pkg::CUSTOMER_REVISION});
		rd_reg(protected_regs_pkg::OFF_MASK_REVISION, {8'h00, protected_regs_pkg::ROM_MASK_REVISION});
		rd_reg(8'h55, 16'h0000);
		for (int i = 0; i < 7; i++) begin
			wr_reg(prot[i], rnd());
			rd_reg(prot[i], stored[i]);
		end
		$display("test reset, identity and lock done");
		wr_reg(protected_regs_pkg::OFF_LOCK_KEY, protected_regs_pkg::LOCK_KEY_UNLOCK);
		repeat (2) @(negedge clk_in);
		chk("unlocked", 16'h0001, {15'h0000, unl});
		for (int i = 0; i < 7; i++) begin
			v = rnd();
			if (i == 3)
				v[10] = 1'b0;
			stored[i] = v;
			wr_reg(prot[i], v);
			rd_reg(prot[i], v);
		end
		rd_reg(protected_regs_pkg::OFF_TICK_CONTROL, 16'h0000);
		chk("osc enable", 16'h0000, {15'h0000, xen});
		wr_reg(protected_regs_pkg::OFF_LOCK_KEY, rnd() | 16'h0100);
		repeat (2) @(negedge clk_in);
		chk("unlocked", 16'h0000, {15'h0000, unl});
		for (int i = 0; i < 7; i++) begin
			wr_reg(prot[i], rnd());
			rd_reg(prot[i], stored[i]);
		end
		wr_reg(protected_regs_pkg::OFF_TICK_CONTROL, 16'h1000);
		repeat (2) @(negedge clk_in);
		chk("osc enable", 16'h0001, {15'h0000, xen});
		rd_reg(protected_regs_pkg::OFF_POWER_MGMT, stored[3] | 16'h0400);
		$display("test unlock, relock and alias done");
		for (int k = 0; k < 9; k++)
			path(k);
		count("rc", 10);
		count("fast", 10);
		count("slow", 5);
		$display("test clock paths and ticks done");
		wr_reg(protected_regs_pkg::OFF_LOCK_KEY, protected_regs_pkg::LOCK_KEY_UNLOCK);
		repeat (4) @(posedge clk_in);
		rstn_in <= 1'b0;
		repeat (5) @(posedge clk_in);
		rstn_in <= 1'b1;
		rd_reg(protected_regs_pkg::OFF_LOCK_KEY, 16'h0000);
		rd_reg(protected_regs_pkg::OFF_POWER_MGMT, 16'h0400);
		chk("unlocked", 16'h0000, {15'h0000, unl});
		repeat (4) @(negedge clk_in);
		$display("test second reset done");
		test_done();
	end
endmodule
`default_nettype wire
